// File: core/ug_pin_sync.sv
// Three-stage pin synchroniser with agreement filter.
// Assumes an asynchronous pin level on the input.
`timescale 1ns/1ns
module ug_pin_sync
  import ug_pkg::*;
#(
  parameter int unsigned W = 1
)
(
  input  wire logic         core_clk,
  input  wire logic         arst_n,
  input  wire logic         ce,
  input  wire logic [W-1:0] pin,
  output logic      [W-1:0] level
);

  logic [W-1:0] s1_ff;
  logic [W-1:0] s2_ff;
  logic [W-1:0] s3_ff;
  logic [W-1:0] lvl_ff;
  logic [W-1:0] nxt_lvl;

  // A change counts once stages two and three agree
  always_comb
  begin
    nxt_lvl = lvl_ff;
    for (int i = 0; i < int'(W); i++)
      if (s2_ff[i] == s3_ff[i])
        nxt_lvl[i] = s3_ff[i];
  end

  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      s1_ff  <= '0;
      s2_ff  <= '0;
      s3_ff  <= '0;
      lvl_ff <= '0;
    end
    else if (ce)
    begin
      s1_ff  <= pin;
      s2_ff  <= s1_ff;
      s3_ff  <= s2_ff;
      lvl_ff <= nxt_lvl;
    end
  end

  assign level = lvl_ff;

endmodule // ug_pin_sync

// File: core/ug_skid_buf.sv
// Two-entry buffer: head register plus one skid entry.
// Assumes both sides on core_clk; ready and valid come from flops.
`timescale 1ns/1ns
module ug_skid_buf
  import ug_pkg::*;
(
  input  wire logic core_clk,
  input  wire logic arst_n,
  input  wire logic ce,
  ug_stream_if.snk  in_s,
  ug_stream_if.src  out_s
);

  localparam int unsigned W = $bits(in_s.data);

  logic [W-1:0] d0_ff;
  logic [W-1:0] d1_ff;
  logic         v0_ff;
  logic         v1_ff;
  logic [W-1:0] nxt_d0;
  logic [W-1:0] nxt_d1;
  logic         nxt_v0;
  logic         nxt_v1;
  logic         rdy_ff;
  logic         nxt_rdy;
  logic         push;
  logic         pop;

  assign push = in_s.valid & ~v1_ff;
  assign pop  = v0_ff & out_s.ready;

  always_comb
  begin
    nxt_d0 = d0_ff;
    nxt_d1 = d1_ff;
    nxt_v0 = v0_ff;
    nxt_v1 = v1_ff;
    if (pop)
      nxt_v0 = 1'b0;
    if (pop && v1_ff)
    begin
      nxt_d0 = d1_ff;
      nxt_v0 = 1'b1;
      nxt_v1 = 1'b0;
    end
    if (push)
    begin
      if (!nxt_v0)
      begin
        nxt_d0 = in_s.data;
        nxt_v0 = 1'b1;
      end
      else
      begin
        nxt_d1 = in_s.data;
        nxt_v1 = 1'b1;
      end
    end
    nxt_rdy = ~nxt_v1;
  end

  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      d0_ff <= '0;
      d1_ff <= '0;
      v0_ff <= 1'b0;
      v1_ff <= 1'b0;
      rdy_ff <= 1'b1;
    end
    else if (ce)
    begin
      d0_ff <= nxt_d0;
      d1_ff <= nxt_d1;
      v0_ff <= nxt_v0;
      v1_ff <= nxt_v1;
      rdy_ff <= nxt_rdy;
    end
  end

  assign in_s.ready  = rdy_ff;
  assign out_s.valid = v0_ff;
  assign out_s.data  = d0_ff;

endmodule // ug_skid_buf

// File: core/ug_usb_glue.sv
// USB device glue: pull-up control, two-level interrupts, receive path.
// Assumes a full-speed core on the same clock giving event levels/pulses
// and a byte stream; the CPU side reads through plain ports.
`timescale 1ns/1ns
module ug_usb_glue
  import ug_pkg::*;
(
  input  wire logic                core_clk,
  input  wire logic                arst_n,
  input  wire logic                ce,
  input  wire logic                cfg_self_powered,
  input  wire logic                connect_en,
  input  wire logic                vbus_pin,
  input  wire logic [1:0]          fast_sel,
  input  wire logic [SRC_N-1:0]    core_evt,
  input  wire logic                clr_wr,
  input  wire logic [STAT_W-1:0]   clr_bits,
  input  wire logic [DATA_W-1:0]   core_rx_data,
  input  wire logic [EP_W-1:0]     core_rx_ep,
  input  wire logic                core_rx_last,
  input  wire logic                core_rx_valid,
  output logic                     core_rx_ready,
  input  wire logic                rx_rd,
  output logic [DATA_W-1:0]        rx_data,
  output logic [EP_W-1:0]          rx_ep,
  output logic                     rx_last,
  output logic                     rx_valid,
  output logic [CNT_W-1:0]         rx_count,
  output logic                     rx_oversize,
  output logic                     bulk_bank,
  output logic                     iso_bank,
  output logic                     self_powered,
  output logic                     vbus_ok,
  output logic                     usb_connect_n,
  output logic                     high_priority_int_out,
  output logic                     low_priority_int_out,
  output logic [STAT_W-1:0]        int_status
);

  //////////////////////////////////////////////////////////////////////////
  // Receive path through the two-entry buffer

  ug_stream_if #(.W(BUF_W)) in_s ();
  ug_stream_if #(.W(BUF_W)) out_s ();

  assign in_s.data   = {core_rx_ep, core_rx_last, core_rx_data};
  assign in_s.valid  = core_rx_valid;
  assign out_s.ready = rx_rd;

  ug_skid_buf u_buf
  (
    .core_clk (core_clk),
    .arst_n   (arst_n),
    .ce       (ce),
    .in_s     (in_s),
    .out_s    (out_s)
  );

  assign core_rx_ready = in_s.ready;
  assign rx_valid      = out_s.valid;
  assign rx_data       = out_s.data[DATA_W-1:0];
  assign rx_last       = out_s.data[DATA_W];
  assign rx_ep         = out_s.data[BUF_W-1:DATA_W+1];

  logic fire;
  logic pkt_done;

  assign fire     = out_s.valid & rx_rd;
  assign pkt_done = fire & rx_last;

  //////////////////////////////////////////////////////////////////////////
  // Per-packet byte count and bank tracking

  logic [CNT_W-1:0] cnt_ff;
  logic [CNT_W-1:0] count_ff;
  logic             over_ff;
  logic             bulk_bank_ff;
  logic             iso_bank_ff;
  logic [CNT_W-1:0] nxt_cnt;
  logic [CNT_W-1:0] nxt_count;
  logic             nxt_over;
  logic             nxt_bulk_bank;
  logic             nxt_iso_bank;
  logic [CNT_W-1:0] cnt_inc;

  // Saturates rather than wrapping on a runaway packet
  assign cnt_inc = (&cnt_ff) ? cnt_ff : cnt_ff + CNT_W'(1);

  always_comb
  begin
    nxt_cnt       = cnt_ff;
    nxt_count     = count_ff;
    nxt_over      = over_ff;
    nxt_bulk_bank = bulk_bank_ff;
    nxt_iso_bank  = iso_bank_ff;
    if (fire)
      nxt_cnt = cnt_inc;
    if (pkt_done)
    begin
      nxt_cnt   = '0;
      nxt_count = cnt_inc;
      nxt_over  = cnt_inc > ug_mps(rx_ep);
      if (rx_ep == UG_EP_BULK)
        nxt_bulk_bank = ~bulk_bank_ff;
      if (rx_ep == UG_EP_ISO)
        nxt_iso_bank = ~iso_bank_ff;
    end
  end

  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      cnt_ff       <= '0;
      count_ff     <= '0;
      over_ff      <= 1'b0;
      bulk_bank_ff <= 1'b0;
      iso_bank_ff  <= 1'b0;
    end
    else if (ce)
    begin
      cnt_ff       <= nxt_cnt;
      count_ff     <= nxt_count;
      over_ff      <= nxt_over;
      bulk_bank_ff <= nxt_bulk_bank;
      iso_bank_ff  <= nxt_iso_bank;
    end
  end

  assign rx_count    = count_ff;
  assign rx_oversize = over_ff;
  assign bulk_bank   = bulk_bank_ff;
  assign iso_bank    = iso_bank_ff;

  //////////////////////////////////////////////////////////////////////////
  // Power report and soft connect

  logic vbus_lvl;
  logic self_pwr_ff;
  logic conn_n_ff;
  logic nxt_self_pwr;
  logic nxt_conn_n;

  ug_pin_sync #(.W(1)) u_vbus
  (
    .core_clk (core_clk),
    .arst_n   (arst_n),
    .ce       (ce),
    .pin      (vbus_pin),
    .level    (vbus_lvl)
  );

  always_comb
  begin
    nxt_self_pwr = cfg_self_powered;
    nxt_conn_n   = ~(connect_en & (vbus_lvl | cfg_self_powered));
  end

  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      self_pwr_ff <= 1'b0;
      conn_n_ff   <= 1'b1;
    end
    else if (ce)
    begin
      self_pwr_ff <= nxt_self_pwr;
      conn_n_ff   <= nxt_conn_n;
    end
  end

  assign self_powered  = self_pwr_ff;
  assign vbus_ok       = vbus_lvl;
  assign usb_connect_n = conn_n_ff;

  //////////////////////////////////////////////////////////////////////////
  // Interrupt status, routing and outputs

  logic [2:0]        fsel_idx;
  logic [STAT_W-1:0] stat_ff;
  logic [STAT_W-1:0] nxt_stat;
  logic [STAT_W-1:0] set_vec;
  logic [STAT_W-1:0] clr_vec;
  logic              hi_ff;
  logic              lo_ff;
  logic              nxt_hi;
  logic              nxt_lo;

  assign fsel_idx = ug_fsel_idx(fast_sel);
  assign clr_vec  = clr_wr ? clr_bits : '0;

  assign set_vec[ST_FAST]    = core_evt[fsel_idx];
  assign set_vec[ST_PKT_END] = pkt_done;

  // Routed source never sets its own low-priority bit
  for (genvar g = 0; g < SRC_N; g++)
  begin : g_src
    assign set_vec[ST_CORE_LO+g] = core_evt[g] && (fsel_idx != 3'(g));
  end

  always_comb
  begin
    nxt_stat = (stat_ff & ~clr_vec) | set_vec;
    nxt_hi   = stat_ff[ST_FAST];
    nxt_lo   = |stat_ff[STAT_W-1:ST_CORE_LO];
  end

  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      stat_ff <= STAT_RST;
      hi_ff   <= 1'b0;
      lo_ff   <= 1'b0;
    end
    else if (ce)
    begin
      stat_ff <= nxt_stat;
      hi_ff   <= nxt_hi;
      lo_ff   <= nxt_lo;
    end
  end

  assign int_status            = stat_ff;
  assign high_priority_int_out = hi_ff;
  assign low_priority_int_out  = lo_ff;

  //////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!arst_n);

  chk_fast_route_set: assert property (
    ce && core_evt[fsel_idx] |=> stat_ff[ST_FAST] ##1 (!ce || hi_ff))
    else $error("routed event did not reach fast line");

  chk_fast_only_one: assert property (
    ce && !stat_ff[ST_FAST] && !core_evt[fsel_idx] && $stable(stat_ff[ST_FAST])
      |=> !ce || !hi_ff)
    else $error("fast line raised without routed source");

  chk_low_excludes: assert property (
    ce && core_evt[fsel_idx] && !stat_ff[ST_CORE_LO+fsel_idx]
      |=> !stat_ff[ST_CORE_LO + $past(fsel_idx)])
    else $error("routed source leaked into low status");

  chk_fast_clear: assert property (
    ce && clr_wr && clr_bits[ST_FAST] && !core_evt[fsel_idx]
      |=> !stat_ff[ST_FAST])
    else $error("fast clear ignored");

  chk_set_over_clear: assert property (
    ce && core_evt[SRC_N-1] && fsel_idx != 3'(SRC_N-1) && clr_wr
      |=> stat_ff[ST_CORE_LO+SRC_N-1])
    else $error("clear beat a persisting source");

  chk_pend_holds: assert property (
    stat_ff[ST_PKT_END] && !(ce && clr_wr && clr_bits[ST_PKT_END])
      |=> stat_ff[ST_PKT_END])
    else $error("pending bit dropped without clear");

  chk_pkt_end_evt: assert property (
    ce && pkt_done |=> stat_ff[ST_PKT_END] ##1 (!ce || lo_ff))
    else $error("packet end not raised");

  chk_count_latch: assert property (
    ce && pkt_done && !(&cnt_ff) |=> count_ff == $past(cnt_ff) + CNT_W'(1))
    else $error("packet byte count wrong");

  chk_bulk_bank: assert property (
    ce && pkt_done && rx_ep == UG_EP_BULK |=> bulk_bank_ff != $past(bulk_bank_ff))
    else $error("bulk bank did not swap");

  chk_connect_off: assert property (
    ce && !connect_en |=> usb_connect_n)
    else $error("connect asserted while disabled");

  chk_iso_bank: assert property (
    ce && pkt_done && rx_ep == UG_EP_ISO |=> iso_bank_ff != $past(iso_bank_ff))
    else $error("iso bank did not swap");

  chk_oversize: assert property (
    ce && pkt_done && !(&cnt_ff) |=> over_ff == ($past(cnt_ff) >= ug_mps($past(rx_ep))))
    else $error("oversize flag wrong");

  chk_low_follows: assert property (
    ce && (|stat_ff[STAT_W-1:ST_CORE_LO]) |=> lo_ff)
    else $error("low line missed a pending source");

  chk_self_power: assert property (
    ce |=> self_powered == $past(cfg_self_powered))
    else $error("power report not taken");

  chk_connect_on: assert property (
    ce && connect_en && cfg_self_powered |=> !usb_connect_n)
    else $error("connect not asserted");

  chk_skid_stall: assert property (
    ce && rx_valid && !rx_rd && core_rx_valid && core_rx_ready |=> !core_rx_ready)
    else $error("buffer accepted past its depth");

  cov_fast_evt:  cover property (ce && core_evt[fsel_idx] ##1 hi_ff);
  cov_pkt_end:   cover property (ce && pkt_done ##[1:3] lo_ff);
  cov_buf_stall: cover property (core_rx_valid && !core_rx_ready);
  cov_fast_clr:  cover property (hi_ff && clr_wr && clr_bits[ST_FAST]);
  cov_fsel_spare: cover property (ce && fast_sel == 2'h2 && core_evt[SRC_FRAME] ##1 stat_ff[ST_FAST]);

endmodule // ug_usb_glue

// File: inc/ug_pkg.sv
// Constants, types and helpers for the USB device interrupt glue.
// Assumes one 100 MHz core clock and a full-speed core on the link side.
// How it works
// - Link runs full speed, 12 Mbit/s.
// - Software selects bus- or self-powered report.
// - Control endpoint carries 8-byte packets.
// - Two interrupt endpoints, 16-byte packets each.
// - Bulk endpoint 64 bytes, two banks.
// - Isochronous endpoint 294 bytes, two banks.
// - Active-low connect output switches pull-up.
// - Select routes frame/bulk event to fast interrupt.
// - Fast interrupt has exactly one source.
// - Low interrupt takes all other sources.
// - Clear bit 0 clears fast interrupt.
// - One status bit per source, cleared individually.
// - Packet end event after last byte delivered.
// - Received byte count reported per packet.
package ug_pkg;

  localparam int unsigned LINK_RATE_BPS = 12_000_000;
  localparam int unsigned CLK_HZ        = 100_000_000;
  localparam int unsigned INIT_LIMIT_MS = 120;

  localparam int unsigned CTRL_MPS  = 8;
  localparam int unsigned INTR_MPS  = 16;
  localparam int unsigned INTR_EPS  = 2;
  localparam int unsigned BULK_MPS  = 64;
  localparam int unsigned ISO_MPS   = 294;
  localparam int unsigned CNT_W     = 9;
  localparam int unsigned DATA_W    = 8;
  localparam int unsigned EP_W      = 3;
  localparam int unsigned BUF_W     = DATA_W + EP_W + 1;

  localparam int unsigned SRC_N      = 8;
  localparam int unsigned SRC_FRAME  = 0;
  localparam int unsigned SRC_BULK_O = 1;
  localparam int unsigned SRC_BULK_I = 2;

  localparam int unsigned STAT_W      = 10;
  localparam int unsigned ST_FAST     = 0;
  localparam int unsigned ST_CORE_LO  = 1;
  localparam int unsigned ST_PKT_END  = 9;
  localparam logic [STAT_W-1:0] STAT_RST = 10'h000;

  typedef enum logic [1:0]
  {
    UG_FSEL_FRAME  = 2'h0,
    UG_FSEL_BULK_O = 2'h1,
    UG_FSEL_BULK_I = 2'h3
  } ug_fsel_e;

  typedef enum logic [EP_W-1:0]
  {
    UG_EP_CTRL  = 3'h0,
    UG_EP_INT1  = 3'h1,
    UG_EP_INT2  = 3'h2,
    UG_EP_BULK  = 3'h3,
    UG_EP_ISO   = 3'h4
  } ug_ep_e;

  // Source index routed to the fast line; unused code falls to frame
  function automatic logic [2:0] ug_fsel_idx(input logic [1:0] sel);
    logic [2:0] idx;
    idx = 3'(SRC_FRAME);
    if (sel == UG_FSEL_BULK_O)
      idx = 3'(SRC_BULK_O);
    else if (sel == UG_FSEL_BULK_I)
      idx = 3'(SRC_BULK_I);
    return idx;
  endfunction

  // Largest legal packet for an endpoint
  function automatic logic [CNT_W-1:0] ug_mps(input logic [EP_W-1:0] ep);
    logic [CNT_W-1:0] m;
    m = CNT_W'(CTRL_MPS);
    if (ep == UG_EP_INT1 || ep == UG_EP_INT2)
      m = CNT_W'(INTR_MPS);
    else if (ep == UG_EP_BULK)
      m = CNT_W'(BULK_MPS);
    else if (ep == UG_EP_ISO)
      m = CNT_W'(ISO_MPS);
    return m;
  endfunction

endpackage

// File: inc/ug_stream_if.sv
// Valid/ready stream between the glue's own modules.
// Assumes source and sink share one clock.
`timescale 1ns/1ns
interface ug_stream_if #(parameter int unsigned W = 8);
  logic [W-1:0] data;
  logic         valid;
  logic         ready;
  modport src (output data, output valid, input ready);
  modport snk (input data, input valid, output ready);
endinterface

// File: verification/test_ug_usb_glue.sv
// Self-checking bench for the USB device interrupt glue.
// Assumes the core model on the receive stream; ce tied high.
`timescale 1ns/1ns
module test_ug_usb_glue;
  import ug_pkg::*;
  logic              core_clk, arst_n, cfg_self_powered, connect_en, vbus_pin;
  logic [1:0]        fast_sel;
  logic [SRC_N-1:0]  core_evt;
  logic              clr_wr, rx_rd, core_rx_ready, core_rx_last, core_rx_valid;
  logic [STAT_W-1:0] clr_bits, int_status;
  logic [DATA_W-1:0] core_rx_data, rx_data;
  logic [EP_W-1:0]   core_rx_ep, rx_ep;
  logic              rx_last, rx_valid, rx_oversize, bulk_bank, iso_bank;
  logic              self_powered, vbus_ok, usb_connect_n, hi_int, lo_int;
  logic [CNT_W-1:0]  rx_count;
  int                n_errors, tests_run, cyc;

  ug_usb_glue i_ug_usb_glue (.core_clk(core_clk), .arst_n(arst_n), .ce(1'b1),
    .cfg_self_powered(cfg_self_powered), .connect_en(connect_en), .vbus_pin(vbus_pin),
    .fast_sel(fast_sel), .core_evt(core_evt), .clr_wr(clr_wr), .clr_bits(clr_bits),
    .core_rx_data(core_rx_data), .core_rx_ep(core_rx_ep), .core_rx_last(core_rx_last),
    .core_rx_valid(core_rx_valid), .core_rx_ready(core_rx_ready), .rx_rd(rx_rd),
    .rx_data(rx_data), .rx_ep(rx_ep), .rx_last(rx_last), .rx_valid(rx_valid),
    .rx_count(rx_count), .rx_oversize(rx_oversize), .bulk_bank(bulk_bank),
    .iso_bank(iso_bank), .self_powered(self_powered), .vbus_ok(vbus_ok),
    .usb_connect_n(usb_connect_n), .high_priority_int_out(hi_int),
    .low_priority_int_out(lo_int), .int_status(int_status));

  ug_core_model i_ug_core_model (.core_clk(core_clk), .core_rx_ready(core_rx_ready),
    .core_rx_data(core_rx_data), .core_rx_ep(core_rx_ep), .core_rx_last(core_rx_last),
    .core_rx_valid(core_rx_valid));

  ////////////////////////////////////////////////////////////////////
  initial
  begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  always @(posedge core_clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      n_errors++;
      report_and_stop();
    end
  end

  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    tests_run++;
    if (got !== exp)
    begin
      n_errors++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask

  task automatic clr(input logic [STAT_W-1:0] m);
    @(posedge core_clk);
    clr_wr   <= 1'b1;
    clr_bits <= m;
    @(posedge core_clk);
    clr_wr   <= 1'b0;
  endtask

  ////////////////////////////////////////////////////////////////////
  task automatic t_conn();
    @(posedge core_clk);
    connect_en <= 1'b1;
    tick(3);
    chk("connect_n novbus", 16'h1, 16'(usb_connect_n));
    @(posedge core_clk);
    vbus_pin <= 1'b1;
    tick(8);
    chk("vbus_ok", 16'h1, 16'(vbus_ok));
    chk("connect_n on", 16'h0, 16'(usb_connect_n));
    @(posedge core_clk);
    vbus_pin         <= 1'b0;
    cfg_self_powered <= 1'b1;
    tick(8);
    chk("self_powered", 16'h1, 16'(self_powered));
    chk("connect_n self", 16'h0, 16'(usb_connect_n));
    @(posedge core_clk);
    connect_en <= 1'b0;
    tick(2);
    chk("connect_n off", 16'h1, 16'(usb_connect_n));
    $display("done t_conn");
  endtask

  // All three routable sources at once; only the chosen one is fast
  task automatic t_fast();
    logic [1:0]  code [4] = '{2'h0, 2'h1, 2'h3, 2'h2};
    int unsigned src  [4] = '{0, 1, 2, 0};
    for (int s = 0; s < 4; s++)
    begin
      @(posedge core_clk);
      fast_sel <= code[s];
      core_evt <= 8'h07;
      @(posedge core_clk);
      core_evt <= 8'h00;
      tick(1);
      chk("status fast", 16'(10'h00F & ~(10'h002 << src[s])), 16'(int_status));
      chk("fast out", 16'h1, 16'(hi_int));
      chk("low out", 16'h1, 16'(lo_int));
      clr(10'h00F);
      tick(2);
      chk("status clr", 16'h0, 16'(int_status));
      chk("fast out clr", 16'h0, 16'(hi_int));
    end
    $display("done t_fast");
  endtask

  // Clear while the source persists, then after the core is cleared
  task automatic t_low();
    @(posedge core_clk);
    fast_sel <= 2'h0;
    core_evt <= 8'h80;
    tick(2);
    chk("status src7", 16'h100, 16'(int_status));
    chk("low out", 16'h1, 16'(lo_int));
    chk("fast out", 16'h0, 16'(hi_int));
    clr(10'h100);
    tick(1);
    chk("status held", 16'h100, 16'(int_status));
    @(posedge core_clk);
    core_evt <= 8'h00;
    clr(10'h100);
    tick(2);
    chk("status low clr", 16'h0, 16'(int_status));
    chk("low out clr", 16'h0, 16'(lo_int));
    $display("done t_low");
  endtask

  task automatic t_pkt(input logic [EP_W-1:0] ep, input int n, input logic ovs, input int stall);
    logic bb;
    logic ib;
    int   w;
    bb = bulk_bank;
    ib = iso_bank;
    fork
      i_ug_core_model.send_pkt(ep, n, 8'(n));
    join_none
    tick(stall);
    if (stall > 4 && n > 2)
      chk("core_rx_ready", 16'h0, 16'(core_rx_ready));
    @(posedge core_clk);
    rx_rd <= 1'b1;
    for (int i = 0; i < n; i++)
    begin
      w = 0;
      do
      begin
        @(posedge core_clk);
        w++;
      end
      while (rx_valid !== 1'b1 && w < 50);
      chk("rx_byte", 16'({ep, i == n - 1, 8'(n + i)}), 16'({rx_ep, rx_last, rx_data}));
    end
    rx_rd <= 1'b0;
    tick(1);
    chk("rx_count", 16'(n), 16'(rx_count));
    chk("rx_oversize", 16'(ovs), 16'(rx_oversize));
    chk("status end", 16'h200, 16'(int_status));
    chk("bulk_bank", 16'(bb ^ (ep == UG_EP_BULK)), 16'(bulk_bank));
    chk("iso_bank", 16'(ib ^ (ep == UG_EP_ISO)), 16'(iso_bank));
    tick(1);
    chk("low out end", 16'h1, 16'(lo_int));
    clr(10'h200);
    tick(2);
    chk("low out idle", 16'h0, 16'(lo_int));
    $display("done t_pkt");
  endtask

  task automatic report_and_stop();
    $display("Comparisons %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////
  initial
  begin
    arst_n           = 1'b0;
    cfg_self_powered = 1'b0;
    connect_en       = 1'b0;
    vbus_pin         = 1'b0;
    fast_sel         = 2'h0;
    core_evt         = 8'h00;
    clr_wr           = 1'b0;
    clr_bits         = 10'h000;
    rx_rd            = 1'b0;
    tick(10);
    chk("rst connect_n", 16'h1, 16'(usb_connect_n));
    chk("rst status", 16'h0, 16'(int_status));
    @(posedge core_clk);
    arst_n <= 1'b1;
    t_conn();
    t_fast();
    t_low();
    t_pkt(UG_EP_BULK, 5, 1'b0, 8);
    t_pkt(UG_EP_BULK, 64, 1'b0, 0);
    t_pkt(UG_EP_BULK, 65, 1'b1, 6);
    t_pkt(UG_EP_CTRL, 8, 1'b0, 0);
    t_pkt(UG_EP_CTRL, 9, 1'b1, 6);
    t_pkt(UG_EP_INT1, 16, 1'b0, 6);
    t_pkt(UG_EP_INT2, 17, 1'b1, 0);
    t_pkt(UG_EP_ISO, 3, 1'b0, 6);
    t_pkt(UG_EP_ISO, 1, 1'b0, 0);
    report_and_stop();
  end
endmodule // test_ug_usb_glue

// File: verification/ug_core_model.sv
// Full-speed core stand-in: hands received bytes to the glue.
// Assumes core_clk shared with the glue; the bench calls send_pkt.
`timescale 1ns/1ns
module ug_core_model
  import ug_pkg::*;
(
  input  wire logic         core_clk,
  input  wire logic         core_rx_ready,
  output logic [DATA_W-1:0] core_rx_data,
  output logic [EP_W-1:0]   core_rx_ep,
  output logic              core_rx_last,
  output logic              core_rx_valid
);
  initial
  begin
    core_rx_data  = 8'h5A;
    core_rx_ep    = 3'h7;
    core_rx_last  = 1'b0;
    core_rx_valid = 1'b0;
  end
  ////////////////////////////////////////////////////////////////////
  // Hold each byte until taken; idle lines show inverted values
  task automatic send_pkt(input logic [EP_W-1:0] ep, input int n, input logic [DATA_W-1:0] b);
    @(posedge core_clk);
    for (int i = 0; i < n; i++)
    begin
      core_rx_data  <= b + DATA_W'(i);
      core_rx_ep    <= ep;
      core_rx_last  <= (i == n - 1);
      core_rx_valid <= 1'b1;
      @(posedge core_clk);
      while (core_rx_ready !== 1'b1)
        @(posedge core_clk);
    end
    core_rx_valid <= 1'b0;
    core_rx_last  <= 1'b0;
    core_rx_data  <= ~core_rx_data;
    core_rx_ep    <= ~ep;
  endtask
endmodule // ug_core_model
